// file: dv/bhc_sec_model.sv
// secondary bus model driving the parity and system error pins
module bhc_sec_model (
	input  logic aclk,
	input  logic par_req,
	input  logic serr_req,
	output logic par_err_n = 1'b1,
	output logic serr_n    = 1'b1
);
	timeunit 1ns;
	timeprecision 1ps;
	// pins are pulled up, so an idle driver reads high; skewed off the edge
	always @(posedge aclk) begin
		par_err_n <= #2 !par_req;
		serr_n    <= #2 !serr_req;
	end
endmodule // bhc_sec_model

// file: dv/bhc_top_assertions.sv
// port assertions for the bridge header control block
module bhc_checker (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic        dn_io_valid,
	input logic        dn_io_forward,
	input logic        dn_mem_valid,
	input logic        dn_vga_forward,
	input logic        ma_valid,
	input logic        ma_is_read,
	input logic        ma_ta_ok,
	input logic        ma_discard,
	input logic        ma_target_abort,
	input logic        sec_parity_err_in_n,
	input logic        sec_parity_report,
	input logic        secondary_system_error_in_n,
	input logic        primary_system_error_out_oe,
	input logic        sec_bus_reset_out_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_rd_abort;
		ma_valid && ma_is_read;
	endsequence
	// synchroniser depth lets the pin lead by three to five edges
	sequence s_par_seen;
		!($past(sec_parity_err_in_n, 3) && $past(sec_parity_err_in_n, 4)
			&& $past(sec_parity_err_in_n, 5));
	endsequence
	sequence secondary_system_error_in_seen;
		!($past(secondary_system_error_in_n, 3)
			&& $past(secondary_system_error_in_n, 4)
			&& $past(secondary_system_error_in_n, 5));
	endsequence
	a_b_retire: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response did not retire");
	a_r_retire: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read data did not retire");
	a_dn_io_cause: assert property (dn_io_forward |->
		$past(dn_io_valid)) else $error("downstream forward without request");
	a_vga_cause: assert property (dn_vga_forward |->
		$past(dn_mem_valid)) else $error("vga forward without request");
	a_rd_no_discard: assert property (s_rd_abort |=> !ma_discard)
		else $error("read abort discarded");
	a_discard_cause: assert property (ma_discard |-> $past(ma_valid) &&
		!$past(ma_is_read)) else $error("discard without write abort");
	a_ta_cause: assert property (ma_target_abort |->
		$past(ma_valid && ma_ta_ok)) else $error("target abort uncaused");
	a_par_cause: assert property (sec_parity_report |-> s_par_seen)
		else $error("parity report without pin");
	a_par_pulse: assert property (sec_parity_report |=>
		!sec_parity_report) else $error("parity report longer than a pulse");
	// abort reaches the pin through two register stages
	a_oe_cause: assert property (primary_system_error_out_oe |->
		secondary_system_error_in_seen or $past(ma_valid, 2)) else $error("system error uncaused");
	a_srst_cause: assert property ($fell(sec_bus_reset_out_n) |->
		s_axi_bvalid || $past(s_axi_bvalid)) else $error("reset without write");
endmodule // bhc_checker

bind bhc_top bhc_checker u_bhc_checker (.aclk(aclk), .aresetn(aresetn),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.dn_io_valid(dn_io_valid), .dn_io_forward(dn_io_forward),
	.dn_mem_valid(dn_mem_valid), .dn_vga_forward(dn_vga_forward),
	.ma_valid(ma_valid), .ma_is_read(ma_is_read), .ma_ta_ok(ma_ta_ok),
	.ma_discard(ma_discard), .ma_target_abort(ma_target_abort),
	.sec_parity_err_in_n(sec_parity_err_in_n),
	.sec_parity_report(sec_parity_report),
	.secondary_system_error_in_n(secondary_system_error_in_n),
	.primary_system_error_out_oe(primary_system_error_out_oe),
	.sec_bus_reset_out_n(sec_bus_reset_out_n));

// file: dv/tb_bridge_header_control_regs.sv
// self-checking bench for the bridge header control registers
`define CHK(g, e) begin \
	samples_checked++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
	end \
end
module tb_bridge_header_control_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [11:0] aw_a = '0, ar_a = '0;
	logic [31:0] w_d = '0, dn_a = '0, mem_a = '0, v, s = 32'h84DA;
	logic [31:0] base = 32'h1000, lim = 32'h1FFF, rd_q;
	logic        awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, dn_v = 0;
	logic        mem_v = 0, ma_v = 0, ma_rd = 0, ma_ta = 0, pse = 0;
	logic        par_q = 0, serr_q = 0;
	logic [1:0]  br_q, rr_q, m;
	wire         awr, wrdy, bv, arr, rv, dn_f, up_f, vga_f, disc, tab;
	wire         par_n, serr_n, srst_n, par_rep, p_n, p_oe, irq;
	wire  [1:0]  br, rres;
	wire  [31:0] rdat, ma_d;
	int          n_fail = 0, samples_checked = 0, i, k, cnt;

	always #5 aclk = ~aclk;

	bhc_top u_bhc_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(aw_a), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
		.s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bry), .s_axi_araddr(ar_a), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rres),
		.s_axi_rvalid(rv), .s_axi_rready(rry), .io_base(base),
		.io_limit(lim), .dn_io_valid(dn_v), .dn_io_addr(dn_a),
		.up_io_valid(dn_v), .up_io_addr(dn_a), .dn_mem_valid(mem_v),
		.dn_mem_addr(mem_a), .dn_io_forward(dn_f), .up_io_forward(up_f),
		.dn_vga_forward(vga_f), .ma_valid(ma_v), .ma_is_read(ma_rd),
		.ma_ta_ok(ma_ta), .primary_system_error_out_enable(pse), .ma_rdata(ma_d),
		.ma_discard(disc), .ma_target_abort(tab),
		.sec_parity_err_in_n(par_n), .secondary_system_error_in_n(serr_n),
		.sec_bus_reset_out_n(srst_n), .sec_parity_report(par_rep),
		.primary_system_error_out_n(p_n),
		.primary_system_error_out_oe(p_oe), .irq(irq));

	bhc_sec_model u_bhc_sec_model (.aclk(aclk), .par_req(par_q),
		.serr_req(serr_q), .par_err_n(par_n), .serr_n(serr_n));

	////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [31:0] exp_ctl(input logic [31:0] x);
		return {9'h0, x[22:16] & 7'h6F, 8'h00, x[7:0]};
	endfunction
	function automatic logic [2:0] exp_fwd(input logic [31:0] a);
		logic in, al, vio;
		in = a >= base && a <= lim;
		al = a[31:16] == 16'h0 && a[9:8] != 2'h0;
		vio = a[31:16] == 16'h0 &&
			a[9:0] inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]};
		return {(in && !(m[0] && al)) || (m[1] && vio),
			!in || (m[0] && al), m[1] && a inside {[32'hA0000:32'hBFFFF]}};
	endfunction

	task report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task tmo;
		n_fail++;
		report_and_stop();
	endtask
	// each task lets one edge pass first, so no signal is driven twice
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		aw_a <= a;
		w_d <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		for (int j = 0; j < 40; j++) begin
			@(posedge aclk);
			if (awr)
				awv <= 1'b0;
			if (wrdy)
				wv <= 1'b0;
			if (bv) begin
				bry <= 1'b0;
				br_q = br;
				return;
			end
		end
		tmo();
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		ar_a <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		for (int j = 0; j < 40; j++) begin
			@(posedge aclk);
			if (arr)
				arv <= 1'b0;
			if (rv) begin
				rry <= 1'b0;
				rd_q = rdat;
				rr_q = rres;
				return;
			end
		end
		tmo();
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rd_q, e)
		`CHK(rr_q, 2'h0)
	endtask
	task automatic pulse_wait(input int n);
		cnt = 0;
		for (k = 0; k < n; k++) begin
			@(posedge aclk);
			if (k == 2)
				par_q <= 1'b0;
			#1;
			cnt += (par_rep === 1'b1) + 2 * (p_oe === 1'b1);
		end
	endtask

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(12'h034, 32'h80);
		rchk(12'h03C, 32'h0);
		wr(12'h034, 32'hFFFF_FFFF);
		rchk(12'h034, 32'h80);
		wr(12'h200, 32'h1);
		`CHK(br_q, 2'h2)
		rd(12'h200);
		`CHK({rr_q, rd_q}, {2'h2, 32'h0})
		for (i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'hFFFF_FFFF : s;
			s = lfsr(s);
			wr(12'h03C, v);
			@(posedge aclk);
			#1;
			`CHK(srst_n, !v[22])
			rchk(12'h03C, exp_ctl(v));
		end
		$display("test registers done");
		for (i = 0; i < 32; i++) begin
			m = i[4:3];
			if (i[2:0] == 3'h0)
				wr(12'h03C, {12'h0, m, 18'h0});
			v = (i[2:0] < 3'h5) ? 32'h1000 + 32'h100 * i[2:0] : lfsr(s);
			if (i[2:0] == 3'h4)
				v = 32'hA0000;
			v = (i[2:0] == 3'h2) ? 32'h13C0 : v;
			s = lfsr(s);
			@(posedge aclk);
			dn_a <= v;
			mem_a <= v;
			dn_v <= 1'b1;
			mem_v <= 1'b1;
			@(posedge aclk);
			dn_v <= 1'b0;
			mem_v <= 1'b0;
			#1;
			`CHK({dn_f, up_f, vga_f}, exp_fwd(v))
		end
		$display("test decode done");
		for (i = 0; i < 8; i++) begin
			wr(12'h03C, {10'h0, i[2], 21'h0});
			@(posedge aclk);
			ma_v <= 1'b1;
			ma_rd <= i[0];
			ma_ta <= i[1];
			pse <= s[3];
			s = lfsr(s);
			@(posedge aclk);
			ma_v <= 1'b0;
			#1;
			`CHK(ma_d, (!i[2] && i[0]) ? 32'hFFFF_FFFF : 32'h0)
			`CHK({disc, tab}, {!i[2] && !i[0], i[2] && i[1]})
			// the pin enable lags the abort outcome by one register
			@(posedge aclk);
			#1;
			`CHK(p_oe, i[2] && !i[1] && pse)
		end
		$display("test abort done");
		wr(12'h104, 32'h1);
		for (i = 0; i < 2; i++) begin
			wr(12'h03C, {15'h0, i[0], 16'h0});
			par_q <= 1'b1;
			pulse_wait(12);
			`CHK(cnt, i)
		end
		#1;
		`CHK(irq, 1'b1)
		wr(12'h104, 32'h0);
		#1;
		`CHK(irq, 1'b0)
		wr(12'h104, 32'h1);
		wr(12'h100, 32'h1);
		#1;
		`CHK(irq, 1'b0)
		$display("test parity done");
		for (i = 0; i < 2; i++) begin
			wr(12'h03C, {14'h0, i[0], 17'h0});
			serr_q <= 1'b1;
			pulse_wait(10);
			serr_q <= 1'b0;
			`CHK(cnt > 0, i == 1)
			`CHK(p_n, 1'b0)
			repeat (8) @(posedge aclk);
		end
		rchk(12'h100, 32'h6);
		$display("test system error done");
		report_and_stop();
	end
endmodule // tb_bridge_header_control_regs

// file: rtl/bhc_abort_ctl.v
// master abort completion and reporting
`include "bhc_regs.vh"

module bhc_abort_ctl (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// control
	input  wire        report_en,
	input  wire        serr_en,
	// abort event
	input  wire        ma_valid,
	input  wire        ma_is_read,
	input  wire        ma_ta_ok,
	// outcome
	output reg  [31:0] ma_rdata,
	output reg         ma_discard,
	output reg         ma_target_abort,
	output reg         ma_serr
);

	always @(posedge aclk) begin
		if (!aresetn) begin
			ma_rdata        <= 32'h00000000;
			ma_discard      <= 1'b0;
			ma_target_abort <= 1'b0;
			ma_serr         <= 1'b0;
		end else begin
			ma_discard      <= ma_valid && !report_en && !ma_is_read; // [R12]
			ma_target_abort <= ma_valid && report_en && ma_ta_ok; // [R13]
			ma_serr <= ma_valid && report_en && !ma_ta_ok && serr_en; // [R13]
			if (ma_valid && ma_is_read && !report_en) begin
				ma_rdata <= `BHC_MA_FILL; // [R12]
			end else if (ma_valid) begin
				ma_rdata <= 32'h00000000;
			end
		end
	end

endmodule // bhc_abort_ctl

// file: rtl/bhc_io_decode.v
// isa alias and vga compatible address qualifiers
`include "bhc_regs.vh"

module bhc_io_decode (
	// control
	input  wire        isa_en,
	input  wire        vga_en,
	// i/o window
	input  wire [31:0] io_base,
	input  wire [31:0] io_limit,
	// addresses
	input  wire [31:0] dn_io_addr,
	input  wire [31:0] up_io_addr,
	input  wire [31:0] dn_mem_addr,
	// qualifiers
	output wire        dn_io_fwd,
	output wire        up_io_fwd,
	output wire        dn_vga_fwd
);

	function in_win;
		input [31:0] a;
		input [31:0] lo;
		input [31:0] hi;
		begin
			in_win = (a >= lo) && (a <= hi);
		end
	endfunction

	// last 768 bytes of a 1KB block, first 64KB only
	function isa_alias;
		input [31:0] a;
		begin
			isa_alias = (a[31:16] == 16'h0000) && (a[9:8] != 2'h0);
		end
	endfunction

	wire dn_in  = in_win(dn_io_addr, io_base, io_limit);
	wire up_in  = in_win(up_io_addr, io_base, io_limit);
	wire vga_io = (dn_io_addr[31:16] == 16'h0000) &&
		(((dn_io_addr[9:0] >= 10'h3B0) && (dn_io_addr[9:0] <= 10'h3BB)) ||
		((dn_io_addr[9:0] >= 10'h3C0) && (dn_io_addr[9:0] <= 10'h3DF)));
	wire vga_mem = (dn_mem_addr >= 32'h000A0000) &&
		(dn_mem_addr <= 32'h000BFFFF);

	assign dn_io_fwd  = (dn_in && !(isa_en && isa_alias(dn_io_addr))) ||
		(vga_en && vga_io); // [R7] [R9] [R10]
	assign up_io_fwd  = !up_in || (isa_en && isa_alias(up_io_addr)); // [R8]
	assign dn_vga_fwd = vga_en && vga_mem; // [R10]

endmodule // bhc_io_decode

// file: rtl/bhc_regs.vh
// bridge header control register map and field constants
`ifndef BHC_REGS_VH
`define BHC_REGS_VH

// byte offsets on the register bus
`define BHC_OFF_CAP       12'h034
`define BHC_OFF_INTCTL    12'h03C
`define BHC_OFF_EVSTAT    12'h100
`define BHC_OFF_EVMASK    12'h104

// capability word
`define BHC_CAP_PTR_RST   8'h80

// interrupt/control word field positions
`define BHC_LINE_LSB      0
`define BHC_LINE_MSB      7
`define BHC_PIN_VAL       8'h00
`define BHC_CTL_LSB       16
`define BHC_CTL_MSB       22
`define BHC_CTL_PERR      0
`define BHC_CTL_SERR      1
`define BHC_CTL_ISA       2
`define BHC_CTL_VGA       3
`define BHC_CTL_RSVD      4
`define BHC_CTL_MAMODE    5
`define BHC_CTL_SRST      6
`define BHC_CTL_RST       7'h00
`define BHC_CTL_WMASK     7'h6F
`define BHC_LINE_RST      8'h00

// event status bits
`define BHC_EV_PERR       0
`define BHC_EV_SERR       1
`define BHC_EV_MABORT     2
`define BHC_EV_W          3

// axi responses
`define BHC_RESP_OKAY     2'h0
`define BHC_RESP_SLVERR   2'h2

// master abort read fill
`define BHC_MA_FILL       32'hFFFFFFFF

`endif

// file: rtl/bhc_top.v
// bridge header control registers with axi4-lite slave
//
// Chosen here: the AXI4-Lite register port.
`include "bhc_regs.vh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// [R1] capability pointer reads 80h, read-only
// [R2] interrupt line is plain read/write storage
// [R3] firmware writes FFh to interrupt line
// [R4] interrupt pin field reads zero, read-only
// [R5] bit 16 enables secondary parity reporting
// [R6] bit 17 forwards secondary system error upstream
// [R7] isa bit blocks downstream alias i/o addresses
// [R8] isa mode forwards secondary alias i/o upstream
// [R9] isa clear forwards whole i/o window
// [R10] bit 19 forwards vga ranges regardless
// [R11] bit 20 reserved, reads zero
// [R12] abort mode clear: ffffffff reads, drop writes
// [R13] abort mode set: target abort or serr
// [R14] bit 22 clear releases secondary reset
// [R15] bit 22 set holds secondary reset
// [R16] control bits reset zero, ro writes ignored
module bhc_top (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	// axi4-lite write response
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	// axi4-lite read data
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// i/o window from the address window registers
	input  wire [31:0] io_base,
	input  wire [31:0] io_limit,
	// datapath decode requests
	input  wire        dn_io_valid,
	input  wire [31:0] dn_io_addr,
	input  wire        up_io_valid,
	input  wire [31:0] up_io_addr,
	input  wire        dn_mem_valid,
	input  wire [31:0] dn_mem_addr,
	// datapath decode answers
	output wire        dn_io_forward,
	output wire        up_io_forward,
	output wire        dn_vga_forward,
	// master abort from datapath
	input  wire        ma_valid,
	input  wire        ma_is_read,
	input  wire        ma_ta_ok,
	input  wire        primary_system_error_out_enable,
	// master abort outcome
	output wire [31:0] ma_rdata,
	output wire        ma_discard,
	output wire        ma_target_abort,
	// secondary pins
	input  wire        sec_parity_err_in_n,
	input  wire        secondary_system_error_in_n,
	output wire        sec_bus_reset_out_n,
	// secondary parity report to datapath
	output wire        sec_parity_report,
	// primary open-drain system error
	output wire        primary_system_error_out_n,
	output wire        primary_system_error_out_oe,
	// interrupt
	output wire        irq
);

	////////////////////////////////////////////////////////////////////
	// register state

	reg  [7:0]           line_r;
	reg  [6:0]           ctl_r;
	reg  [`BHC_EV_W-1:0] ev_stat_r;
	reg  [`BHC_EV_W-1:0] ev_mask_r;

	wire perr_mode = ctl_r[`BHC_CTL_PERR];
	wire serr_fwd  = ctl_r[`BHC_CTL_SERR];
	wire isa_mode  = ctl_r[`BHC_CTL_ISA];
	wire vga_mode  = ctl_r[`BHC_CTL_VGA];
	wire ma_mode   = ctl_r[`BHC_CTL_MAMODE];
	wire srst_mode = ctl_r[`BHC_CTL_SRST];

	////////////////////////////////////////////////////////////////////
	// axi4-lite write channel

	reg         aw_got_r;
	reg  [11:0] aw_addr_r;
	reg         w_got_r;
	reg  [31:0] w_data_r;
	reg  [3:0]  w_strb_r;
	reg         bvalid_r;
	reg  [1:0]  bresp_r;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready  = !w_got_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	wire wr_do = aw_got_r && w_got_r && !bvalid_r;

	function [7:0] merge8;
		input [7:0] old;
		input [7:0] nw;
		input       en;
		begin
			merge8 = en ? nw : old;
		end
	endfunction

	function known_addr;
		input [11:0] a;
		begin
			known_addr = (a == `BHC_OFF_CAP) || (a == `BHC_OFF_INTCTL) ||
				(a == `BHC_OFF_EVSTAT) || (a == `BHC_OFF_EVMASK);
		end
	endfunction

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r  <= 1'b0;
			aw_addr_r <= 12'h000;
			w_got_r   <= 1'b0;
			w_data_r  <= 32'h00000000;
			w_strb_r  <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `BHC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r  <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r  <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_do) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r  <= known_addr(aw_addr_r) ?
					`BHC_RESP_OKAY : `BHC_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// control and line registers

	wire       wr_intctl = wr_do && (aw_addr_r == `BHC_OFF_INTCTL);
	wire [7:0] ctl_byte  = merge8({1'b0, ctl_r}, w_data_r[23:16],
		w_strb_r[2]);

	always @(posedge aclk) begin
		if (!aresetn) begin
			line_r <= `BHC_LINE_RST;
			ctl_r  <= `BHC_CTL_RST; // [R16] [R15]
		end else if (wr_intctl) begin
			line_r <= merge8(line_r, w_data_r[7:0], w_strb_r[0]); // [R2] [R3]
			// reserved bit 20 never stores; byte 1 and pointer ignored
			ctl_r  <= ctl_byte[6:0] & `BHC_CTL_WMASK; // [R11] [R16]
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			ev_mask_r <= {`BHC_EV_W{1'b0}};
		end else if (wr_do && (aw_addr_r == `BHC_OFF_EVMASK) &&
			w_strb_r[0]) begin
			ev_mask_r <= w_data_r[`BHC_EV_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	reg         rvalid_r;
	reg  [31:0] rdata_r;
	reg  [1:0]  rresp_r;
	reg  [31:0] rd_word;
	reg  [1:0]  rd_resp;

	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// unmapped reads answer zero with slverr
	always @* begin
		rd_word = 32'h00000000;
		rd_resp = `BHC_RESP_OKAY;
		if ({s_axi_araddr[11:2], 2'h0} == `BHC_OFF_CAP) begin
			rd_word = {24'h000000, `BHC_CAP_PTR_RST}; // [R1]
		end else if ({s_axi_araddr[11:2], 2'h0} == `BHC_OFF_INTCTL) begin
			rd_word = {9'h000, ctl_r, `BHC_PIN_VAL, line_r}; // [R4] [R11]
		end else if ({s_axi_araddr[11:2], 2'h0} == `BHC_OFF_EVSTAT) begin
			rd_word = {29'h00000000, ev_stat_r};
		end else if ({s_axi_araddr[11:2], 2'h0} == `BHC_OFF_EVMASK) begin
			rd_word = {29'h00000000, ev_mask_r};
		end else begin
			rd_resp = `BHC_RESP_SLVERR;
		end
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= `BHC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_word;
			rresp_r  <= rd_resp;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin synchronisers: three stages, change taken when 2 and 3 agree

	reg [1:0] pin_s1_r;
	reg [1:0] pin_s2_r;
	reg [1:0] pin_s3_r;
	reg [1:0] pin_q_r;
	reg       perr_q_d_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_r   <= 2'h3;
			pin_s2_r   <= 2'h3;
			pin_s3_r   <= 2'h3;
			pin_q_r    <= 2'h3;
			perr_q_d_r <= 1'b1;
		end else begin
			pin_s1_r <= {secondary_system_error_in_n, sec_parity_err_in_n};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			if (pin_s2_r[0] == pin_s3_r[0]) begin
				pin_q_r[0] <= pin_s3_r[0];
			end
			if (pin_s2_r[1] == pin_s3_r[1]) begin
				pin_q_r[1] <= pin_s3_r[1];
			end
			perr_q_d_r <= pin_q_r[0];
		end
	end

	wire sec_serr_act = !pin_q_r[1];
	// parity error counted once per assertion
	wire perr_seen    = perr_q_d_r && !pin_q_r[0];

	////////////////////////////////////////////////////////////////////
	// address qualifiers

	wire dec_dn_io;
	wire dec_up_io;
	wire dec_vga;

	bhc_io_decode u_dec (
		.isa_en     (isa_mode),
		.vga_en     (vga_mode),
		.io_base    (io_base),
		.io_limit   (io_limit),
		.dn_io_addr (dn_io_addr),
		.up_io_addr (up_io_addr),
		.dn_mem_addr(dn_mem_addr),
		.dn_io_fwd  (dec_dn_io),
		.up_io_fwd  (dec_up_io),
		.dn_vga_fwd (dec_vga)
	);

	reg dn_io_fwd_r;
	reg up_io_fwd_r;
	reg dn_vga_fwd_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			dn_io_fwd_r  <= 1'b0;
			up_io_fwd_r  <= 1'b0;
			dn_vga_fwd_r <= 1'b0;
		end else begin
			dn_io_fwd_r  <= dn_io_valid && dec_dn_io; // [R7] [R9] [R10]
			up_io_fwd_r  <= up_io_valid && dec_up_io; // [R8]
			dn_vga_fwd_r <= dn_mem_valid && dec_vga; // [R10]
		end
	end

	assign dn_io_forward  = dn_io_fwd_r;
	assign up_io_forward  = up_io_fwd_r;
	assign dn_vga_forward = dn_vga_fwd_r;

	////////////////////////////////////////////////////////////////////
	// master abort handling

	wire ma_serr_req;

	bhc_abort_ctl u_abort (
		.aclk           (aclk),
		.aresetn        (aresetn),
		.report_en      (ma_mode),
		.serr_en        (primary_system_error_out_enable),
		.ma_valid       (ma_valid),
		.ma_is_read     (ma_is_read),
		.ma_ta_ok       (ma_ta_ok),
		.ma_rdata       (ma_rdata),
		.ma_discard     (ma_discard),
		.ma_target_abort(ma_target_abort),
		.ma_serr        (ma_serr_req)
	);

	////////////////////////////////////////////////////////////////////
	// system error, parity report and secondary reset outputs

	reg serr_drive_r;
	reg perr_rep_r;
	reg srst_n_r;

	always @(posedge aclk) begin
		if (!aresetn) begin
			serr_drive_r <= 1'b0;
			perr_rep_r   <= 1'b0;
			srst_n_r     <= 1'b1;
		end else begin
			// primary error pin held while forwarded, pulsed on abort
			serr_drive_r <= (serr_fwd && sec_serr_act) || ma_serr_req; // [R6] [R13]
			perr_rep_r   <= perr_mode && perr_seen; // [R5]
			srst_n_r     <= !srst_mode; // [R14] [R15]
		end
	end

	assign primary_system_error_out_n  = 1'b0;
	assign primary_system_error_out_oe = serr_drive_r;
	assign sec_parity_report           = perr_rep_r;
	assign sec_bus_reset_out_n         = srst_n_r;

	////////////////////////////////////////////////////////////////////
	// event status, write one to clear; a new event beats the clear

	wire [`BHC_EV_W-1:0] ev_set = {ma_valid && ma_mode,
		serr_fwd && sec_serr_act, perr_mode && perr_seen}; // [R5] [R6]
	wire [`BHC_EV_W-1:0] ev_clr = (wr_do && (aw_addr_r == `BHC_OFF_EVSTAT)
		&& w_strb_r[0]) ? w_data_r[`BHC_EV_W-1:0] : {`BHC_EV_W{1'b0}};

	always @(posedge aclk) begin
		if (!aresetn) begin
			ev_stat_r <= {`BHC_EV_W{1'b0}};
		end else begin
			ev_stat_r <= (ev_stat_r & ~ev_clr) | ev_set;
		end
	end

	assign irq = |(ev_stat_r & ev_mask_r);

endmodule // bhc_top
